// ---- hw/gp5_deb_if.sv ----
`timescale 1ns/1ps
// Raw pad level in, debounce length in, accepted level out
interface gp5_deb_if #(
  parameter int unsigned CNT_W = 13
);
  logic pad_raw;
  logic [CNT_W-1:0] limit;
  logic level;
  modport filt (input pad_raw, input limit, output level);
  modport user (output pad_raw, output limit, input level);
endinterface

// ---- hw/gp5_debounce.sv ----
`timescale 1ns/1ps
module gp5_debounce #(
  parameter int unsigned CNT_W = 13
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Filter side
  gp5_deb_if.filt dbi
);

  logic [2:0] sync_r;
  logic level_r;
  logic [CNT_W-1:0] cnt_r;
  logic agree;
  logic differs;

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser; stage 0 feeds only stage 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], dbi.pad_raw};
    end
  end

  assign agree = (sync_r[1] == sync_r[2]);
  assign differs = agree && (sync_r[2] != level_r);

  ////////////////////////////////////////////////////////////////////////
  // Any bounce restarts the count, so only a steady new level is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      level_r <= 1'h0;
    end else if (differs) begin
      if (cnt_r >= dbi.limit - CNT_W'(1)) begin
        level_r <= sync_r[2];
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end else begin
      cnt_r <= '0;
    end
  end

  assign dbi.level = level_r;

  ////////////////////////////////////////////////////////////////////////
  // A new level is only accepted after the full run of agreeing samples
  deb_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(level_r) |-> $past(cnt_r) >= $past(dbi.limit) - CNT_W'(1))
    else $error("debounced level changed before the hold time");

endmodule // gp5_debounce

// ---- hw/gp5_pin_ctrl.sv ----
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module gp5_pin_ctrl #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DEB_SHORT_CYC = gp5_pkg::DEB_SHORT_CYC,
  parameter int unsigned DEB_LONG_CYC = gp5_pkg::DEB_LONG_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state and alternate source
  input wire logic sleep_active,
  input wire logic third_led_channel_out,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pulldown,
  // Power-up sequencer hook
  output logic seq_owned
);

  localparam int unsigned CW = gp5_pkg::DEB_CNT_W;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] read_val;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic pad_out_r;
  logic pad_oe_r;
  logic pad_pulldown_r;
  logic seq_owned_r;
  logic addr_hit;
  logic setup_phase;
  logic access_done;
  logic wr_hit;
  logic pad_level;
  logic dir_out;
  logic sleep_low;
  logic src_sel;
  logic open_drain;
  logic out_value;
  logic force_low;
  logic drive_level;
  logic drive_en;

  gp5_deb_if #(.CNT_W(CW)) dbi ();

  ////////////////////////////////////////////////////////////////////////
  // Field views of the control register
  assign out_value = ctrl_r[gp5_pkg::BIT_OUT_VALUE];
  assign dir_out = ctrl_r[gp5_pkg::BIT_DIR_OUT];
  assign src_sel = ctrl_r[gp5_pkg::BIT_SRC_SEL];
  assign open_drain = ctrl_r[gp5_pkg::BIT_OPEN_DRAIN];
  assign sleep_low = ctrl_r[gp5_pkg::BIT_SLEEP_LOW];

  ////////////////////////////////////////////////////////////////////////
  // Input filter; length picked live by the select bit
  assign dbi.pad_raw = pad_in;
  assign dbi.limit = ctrl_r[gp5_pkg::BIT_DEB_SEL] ? CW'(DEB_LONG_CYC)
                                                  : CW'(DEB_SHORT_CYC);
  assign pad_level = dbi.level;

  gp5_debounce #(.CNT_W(CW)) u_deb (
    .pclk(pclk),
    .presetn(presetn),
    .dbi(dbi)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode: one aligned word, low two address bits must be zero
  assign addr_hit = (paddr == ADDR_W'(gp5_pkg::CTRL_ADDR));
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_r;
  assign wr_hit = access_done && pwrite && addr_hit;

  // Status bit comes from the pad, never from storage
  always_comb begin
    read_val = ctrl_r;
    read_val[gp5_pkg::BIT_PAD_STS] = pad_level;
  end

  // Only writable bits take bus data; status bit stays clear in storage
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_hit) begin
      ctrl_nxt = pwdata[7:0] & gp5_pkg::CTRL_RW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register; defaults are the programmed zero values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= gp5_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer: no wait state, read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'h0;
      pslverr_r <= 1'h0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_phase;
      pslverr_r <= setup_phase && !addr_hit;
      if (setup_phase) begin
        prdata_r <= (addr_hit && !pwrite) ? {24'h00_0000, read_val} : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output source: sleep low first, then the source mux
  assign force_low = sleep_low && sleep_active && dir_out;
  assign drive_level = force_low ? 1'h0 :
                       (src_sel ? third_led_channel_out : out_value);
  // Open drain drives only low, on whichever source won
  assign drive_en = dir_out && (!open_drain || !drive_level);

  ////////////////////////////////////////////////////////////////////////
  // Pad drive, registered so the pad never sees mux glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_r <= 1'h0;
      pad_oe_r <= 1'h0;
    end else begin
      pad_out_r <= drive_level;
      pad_oe_r <= drive_en;
    end
  end

  // Pulldown control follows its bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_pulldown_r <= 1'h0;
    end else begin
      pad_pulldown_r <= ctrl_r[gp5_pkg::BIT_PULLDOWN];
    end
  end

  // An output pin is claimed by the power-up sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_owned_r <= 1'h0;
    end else begin
      seq_owned_r <= dir_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output ports
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign pad_pulldown = pad_pulldown_r;
  assign seq_owned = seq_owned_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus phases
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_access_s;
    psel && penable && pready;
  endsequence

  sequence ctrl_write_s;
    apb_access_s ##0 (pwrite && addr_hit);
  endsequence

  sequence status_read_s;
    apb_setup_s ##0 (!pwrite && addr_hit);
  endsequence

  // Writes land on the writable bits, the status bit stays out of storage
  property ctrl_write_p;
    ctrl_write_s |=> ctrl_r == ($past(pwdata[7:0]) & gp5_pkg::CTRL_RW_MASK);
  endproperty
  ctrl_write_a: assert property (ctrl_write_p)
    else $error("control write did not land");

  // Read answer shows the filtered pad level in the status bit
  status_read_a: assert property (status_read_s |=>
    prdata[gp5_pkg::BIT_PAD_STS] == $past(pad_level))
    else $error("status bit does not show the pad level");

  // The status bit is never held in storage
  status_store_a: assert property (ctrl_r[gp5_pkg::BIT_PAD_STS] == 1'h0)
    else $error("status bit was stored");

  // Answer comes exactly one cycle after setup
  bus_answer_a: assert property (apb_setup_s |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

  // Unmapped addresses get an error answer
  bus_error_a: assert property ((apb_setup_s ##0 !addr_hit) |=> pready && pslverr)
    else $error("unmapped access not flagged");

  // Forced low in sleep, driven, whatever the source
  sleep_low_a: assert property (force_low |=> pad_oe && !pad_out)
    else $error("pin not forced low in sleep");

  // Override clear: sleep leaves the software value on the pin
  sleep_ignored_a: assert property ((dir_out && !sleep_low && !src_sel) |=>
    pad_out == $past(out_value))
    else $error("sleep changed pin behaviour");

  // Software value reaches the pin
  soft_value_a: assert property ((dir_out && !src_sel && !force_low) |=>
    pad_out == $past(out_value))
    else $error("software value not on pin");

  // LED channel reaches the pin
  led_route_a: assert property ((dir_out && src_sel && !force_low) |=>
    pad_out == $past(third_led_channel_out))
    else $error("LED channel not on pin");

  // Open drain never drives high; push-pull always drives an output
  drive_type_a: assert property (dir_out |=>
    pad_oe == (!$past(open_drain) || !pad_out))
    else $error("drive type wrong");

  // Pulldown follows its bit one cycle later
  pulldown_a: assert property (pad_pulldown == $past(ctrl_r[gp5_pkg::BIT_PULLDOWN]))
    else $error("pulldown not following bit");

  // Input direction never drives the pad
  input_dir_a: assert property (!dir_out |=> !pad_oe)
    else $error("input pin driven");

  // Sequencer claim tracks direction
  seq_claim_a: assert property (seq_owned == $past(dir_out))
    else $error("sequencer claim wrong");

  // Register comes out of reset at its defaults
  reset_value_a: assert property (@(posedge pclk) disable iff (1'h0)
    $rose(presetn) |-> ctrl_r == gp5_pkg::CTRL_RESET)
    else $error("reset value wrong");

  // Further bus phases and pin situations
  sequence bad_addr_s;
    apb_setup_s ##0 !addr_hit;
  endsequence

  sequence good_addr_s;
    apb_setup_s ##0 addr_hit;
  endsequence

  sequence stray_write_s;
    apb_access_s ##0 (pwrite && !addr_hit);
  endsequence

  sequence drive_high_write_s;
    ctrl_write_s ##0 (pwdata[7:0] == 8'h05);
  endsequence

  sequence sleep_led_high_s;
    force_low ##0 (src_sel && third_led_channel_out);
  endsequence

  sequence od_led_high_s;
    (dir_out && !force_low) ##0 (open_drain && src_sel && third_led_channel_out);
  endsequence

  // Unmapped writes leave the register alone
  stray_write_a: assert property (stray_write_s |=> $stable(ctrl_r))
    else $error("unmapped write changed the register");

  // No field moves without a write to the register
  ctrl_hold_a: assert property (!(psel && penable && pready && pwrite && addr_hit) |=>
    $stable(ctrl_r))
    else $error("register changed without a write");

  // Read answer carries the writable fields, upper bits stay zero
  read_fields_a: assert property (status_read_s |=>
    prdata[31:8] == 24'h00_0000 &&
    (prdata[7:0] & gp5_pkg::CTRL_RW_MASK) == ($past(ctrl_r) & gp5_pkg::CTRL_RW_MASK))
    else $error("read data does not show the register");

  // Writes and unmapped reads answer with zero data
  read_zero_a: assert property ((apb_setup_s ##0 (pwrite || !addr_hit)) |=>
    prdata == 32'h0000_0000)
    else $error("write or unmapped access returned data");

  // Mapped accesses answer without an error
  bus_ok_a: assert property (good_addr_s |=> pready && !pslverr)
    else $error("mapped access flagged as error");

  // No answer unless a setup cycle came just before
  bus_idle_a: assert property (!(psel && !penable) |=> !pready)
    else $error("bus answered without a setup");

  // A software high written to an output reaches the pad two edges on
  write_to_pin_a: assert property (drive_high_write_s |=> ##1 (pad_oe && pad_out))
    else $error("written high value not on pin");

  // Sleep low wins over a high LED channel
  sleep_led_a: assert property (sleep_led_high_s |=> pad_oe && !pad_out)
    else $error("LED channel beat the sleep override");

  // Open drain lets go of a high LED level too
  od_led_a: assert property (od_led_high_s |=> !pad_oe && pad_out)
    else $error("open drain drove a high LED level");

  // Sleep override never turns an input into a driver
  sleep_input_a: assert property ((sleep_low && sleep_active && !dir_out) |=> !pad_oe)
    else $error("sleep override drove an input pin");

  // Override clear: LED route keeps working while asleep
  sleep_led_route_a: assert property ((dir_out && sleep_active && !sleep_low && src_sel) |=>
    pad_out == $past(third_led_channel_out))
    else $error("sleep changed the LED route");

  // Push-pull output always drives the pad
  push_pull_a: assert property ((dir_out && !open_drain) |=> pad_oe)
    else $error("push-pull output not driven");

  // An input pin is never claimed by the sequencer
  seq_release_a: assert property (!dir_out |=> !seq_owned)
    else $error("input pin claimed by sequencer");

endmodule // gp5_pin_ctrl

// ---- hw/gp5_pkg.sv ----
// Function
// - Sleep override set, sleeping and pin output: drive the pin low.
// - Sleep override clear: sleep leaves pin behaviour as in active mode.
// - Output with source select 0: software output value appears on the pin.
// - Output with source select 1: third LED channel output appears on the pin.
// - Drive type 0 is push-pull, 1 is open-drain driving only low.
// - Input debounced 94 us with select 0, 156 us with select 1.
// - Pulldown enable bit 0 disables, 1 enables the pad pulldown.
// - Direction bit 0 makes the pad an input, 1 an output.
// - Output direction hands the pin to the power-up sequencer.
// - Pad status bit is read-only, shows pad level, ignores writes.
// - In output mode with source select 0 the output value bit sets the driven level, unless sleep forces it low.
package gp5_pkg;

  // Clock and debounce timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned DEB_SHORT_NS = 94000;
  localparam int unsigned DEB_LONG_NS = 156000;
  // Least times, so round up to whole cycles
  localparam int unsigned DEB_SHORT_CYC = (DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEB_LONG_CYC = (DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEB_CNT_W = 13;

  // Register index and its byte address on the bus
  localparam logic [7:0] CTRL_IDX = 8'h45;
  localparam int unsigned CTRL_ADDR = 4 * int'(CTRL_IDX);

  // Field positions in pin5_control
  localparam int unsigned BIT_OUT_VALUE = 0;
  localparam int unsigned BIT_PAD_STS = 1;
  localparam int unsigned BIT_DIR_OUT = 2;
  localparam int unsigned BIT_PULLDOWN = 3;
  localparam int unsigned BIT_DEB_SEL = 4;
  localparam int unsigned BIT_OPEN_DRAIN = 5;
  localparam int unsigned BIT_SRC_SEL = 6;
  localparam int unsigned BIT_SLEEP_LOW = 7;

  // Programmed defaults and writable bits
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'hFD;

endpackage

// ---- tb/gp5_board.sv ----
`timescale 1ns/1ps
module gp5_board #(
  parameter logic PULL_LEVEL = 1'b1
) (
  // Device pad side
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pad_pulldown,
  // External driver on the board
  input wire logic ext_en,
  input wire logic ext_level,
  // Resolved wire
  output logic pad_level
);
  ////////////////////////////////////////////////////////////////////////////////
  // Two drivers that disagree give an unknown, never a tidy winner
  always_comb begin
    if (pad_oe && ext_en && (pad_out != ext_level)) begin
      pad_level = 1'bx;
    end else if (pad_oe) begin
      pad_level = pad_out;
    end else if (ext_en) begin
      pad_level = ext_level;
    end else if (pad_pulldown) begin
      pad_level = 1'b0;
    end else begin
      pad_level = PULL_LEVEL; // Board pull resistor for open drain
    end
  end
endmodule // gp5_board

// ---- tb/tb_gp5_pin_ctrl.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_gp5_pin_ctrl;
  localparam logic [11:0] A_CTRL = 12'(gp5_pkg::CTRL_ADDR);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sleep_active, led, pad_in, pad_out, pad_oe, pad_pd, seq_owned, ext_en, ext_level;
  logic [7:0] c;
  logic e_lvl, e_oe;
  int n_fail, checks_done, cyc, lim;
  ////////////////////////////////////////////////////////////////////////////////
  // Short debounce counts keep the run brief
  gp5_pin_ctrl #(.DEB_SHORT_CYC(8), .DEB_LONG_CYC(16)) u_gp5_pin_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_active(sleep_active), .third_led_channel_out(led), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pulldown(pad_pd), .seq_owned(seq_owned));
  gp5_board u_gp5_board (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pulldown(pad_pd),
    .ext_en(ext_en), .ext_level(ext_level), .pad_level(pad_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e_rd, input logic e_err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    `CHK("pslverr", e_err, pslverr)
    if (!wr) `CHK("prdata", e_rd, prdata)
    psel <= 1'b0; penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, sleep_active, led, ext_level} = '0;
    paddr = '0; pwdata = '0; ext_en = 1'b1;
    tick(4);
    presetn <= 1'b1;
    apb(0, A_CTRL, 0, 32'h00, 0);
    `CHK("seq_owned", 1'b0, seq_owned)
    apb(1, A_CTRL, 32'hFB, 0, 0);
    apb(0, A_CTRL, 0, 32'hF9, 0);
    apb(1, A_CTRL + 12'h004, 32'h00, 0, 1);
    apb(0, A_CTRL + 12'h004, 0, 32'h00, 1);
    apb(0, A_CTRL, 0, 32'hF9, 0);
    tick(2);
    `CHK("pad_pd", 1'b1, pad_pd)
    `CHK("pad_oe in", 1'b0, pad_oe)
    $display("registers done");
    ext_en <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      c = {i[3], i[1], i[2], 2'b00, 1'b1, 1'b0, i[0]};
      apb(1, A_CTRL, {24'h0, c}, 0, 0);
      sleep_active <= i[4]; led <= ~i[0];
      tick(3);
      e_lvl = (i[3] && i[4]) ? 1'b0 : (i[1] ? ~i[0] : i[0]);
      e_oe = i[2] ? ~e_lvl : 1'b1;
      `CHK("pad_out", e_lvl, pad_out)
      `CHK("pad_oe", e_oe, pad_oe)
      `CHK("seq_owned", 1'b1, seq_owned)
    end
    $display("output modes done");
    ext_en <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      lim = s ? 16 : 8;
      apb(1, A_CTRL, s ? 32'h10 : 32'h00, 0, 0);
      tick(2 * lim);
      ext_level <= 1'b1;
      tick(lim - 2);
      apb(0, A_CTRL, 0, s ? 32'h10 : 32'h00, 0);
      tick(lim + 4);
      apb(0, A_CTRL, 0, s ? 32'h12 : 32'h02, 0);
      ext_level <= 1'b0;
      tick(lim - 4);
      ext_level <= 1'b1;
      tick(lim + 4);
      apb(0, A_CTRL, 0, s ? 32'h12 : 32'h02, 0);
      ext_level <= 1'b0;
      tick(2 * lim);
      apb(0, A_CTRL, 0, s ? 32'h10 : 32'h00, 0);
    end
    $display("debounce done");
    // Reset in mid-run brings every field back to its programmed zero
    apb(1, A_CTRL, 32'hFF, 0, 0);
    tick(2);
    `CHK("pad_pd set", 1'b1, pad_pd)
    `CHK("seq_owned set", 1'b1, seq_owned)
    presetn <= 1'b0;
    tick(2);
    `CHK("pad_pd rst", 1'b0, pad_pd)
    `CHK("pad_oe rst", 1'b0, pad_oe)
    `CHK("seq_owned rst", 1'b0, seq_owned)
    presetn <= 1'b1;
    apb(0, A_CTRL, 0, 32'h00, 0);
    $display("reset done");
    end_of_test();
  end
endmodule // tb_gp5_pin_ctrl
